// ===== nvsc_host.sv
`include "nvsc_regs.svh"
`default_nettype none
module nvsc_host #(
    parameter int ADDR_W     = 20,
    parameter int DATA_W     = 16,
    parameter int RESTORE_CY = (`NVSC_RESTORE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS,
    parameter int SAVE_CY    = (`NVSC_SAVE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS
) (
    // clock, reset, enable
    input  wire logic              i_core_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_ce,
    // user request
    input  wire logic              i_req_valid,
    input  wire logic              i_req_write,
    input  wire logic              i_req_cmd,
    input  wire logic [2:0]        i_req_code,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [DATA_W-1:0] i_req_wdata,
    input  wire logic              i_low_supply,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_rdata,
    // memory pins
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic                   o_mem_chip_sel_n,
    output logic                   o_mem_out_en_n,
    output logic                   o_mem_write_n,
    output logic                   o_upper_byte_select_n,
    output logic                   o_lower_byte_select_n,
    input  wire logic [DATA_W-1:0] i_mem_dq,
    output logic [DATA_W-1:0]      o_mem_dq,
    output logic                   o_mem_dq_oe,
    input  wire logic              i_save_busy_handshake_n
);
    import nvsc_pkg::*;

    localparam int RD_CY  = (`NVSC_RD_PULSE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS;
    localparam int GAP_CY = (`NVSC_GAP_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS;
    localparam int CNT_W  = $clog2(SAVE_CY + RESTORE_CY + 2);

    // ************************************************************
    // command address table
    // ************************************************************
    function automatic logic [15:0] nvsc_step_addr(input logic [2:0] step,
                                                   input logic [2:0] code);
        logic [15:0] a;
        a = `NVSC_CMD_A1;
        case (step)
            3'h0: a = `NVSC_CMD_A1;
            3'h1: a = `NVSC_CMD_A2;
            3'h2: a = `NVSC_CMD_A3;
            3'h3: a = `NVSC_CMD_A4;
            3'h4: a = `NVSC_CMD_A5;
            default:
                case (code)
                    `NVSC_CMD_ENA_OFF: a = `NVSC_CMD_AS_OFF;
                    `NVSC_CMD_ENA_ON:  a = `NVSC_CMD_AS_ON;
                    `NVSC_CMD_SAVE_C:  a = `NVSC_CMD_SAVE;
                    default:           a = `NVSC_CMD_RESTORE;
                endcase
        endcase
        return a;
    endfunction : nvsc_step_addr

    // ************************************************************
    // sequencer
    // ************************************************************
    nvsc_state_e         state_q, state_d;
    logic [CNT_W-1:0]    cnt_q, cnt_d;
    logic [2:0]          step_q, step_d;
    logic                is_cmd_q, is_cmd_d;
    logic                is_wr_q, is_wr_d;
    logic [2:0]          code_q, code_d;
    logic [ADDR_W-1:0]   addr_q, addr_d;
    logic [DATA_W-1:0]   wdata_q, wdata_d;
    logic                ready_q, ready_d;
    logic                rsp_q, rsp_d;
    logic [DATA_W-1:0]   rdata_q, rdata_d;
    logic                cs_n_q, cs_n_d;
    logic                oe_n_q, oe_n_d;
    logic                we_n_q, we_n_d;
    logic                dq_oe_q, dq_oe_d;
    logic [15:0]         step_addr;

    // command address of the current step, sliced when the pins are set
    assign step_addr = nvsc_step_addr(step_q, code_q);

    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        step_d   = step_q;
        is_cmd_d = is_cmd_q;
        is_wr_d  = is_wr_q;
        code_d   = code_q;
        addr_d   = addr_q;
        wdata_d  = wdata_q;
        ready_d  = 1'b0;
        rsp_d    = 1'b0;
        rdata_d  = rdata_q;
        cs_n_d   = cs_n_q;
        oe_n_d   = oe_n_q;
        we_n_d   = we_n_q;
        dq_oe_d  = dq_oe_q;
        case (state_q)
            NVSC_IDLE:
            begin
                ready_d = i_save_busy_handshake_n;
                // low supply: the device would drop writes and saves anyway
                if (ready_q && i_req_valid && i_save_busy_handshake_n &&
                    !(i_low_supply && (i_req_write ||
                      (i_req_cmd && i_req_code == `NVSC_CMD_SAVE_C))))
                begin
                    ready_d  = 1'b0;
                    is_cmd_d = i_req_cmd;
                    is_wr_d  = i_req_write && !i_req_cmd;
                    code_d   = i_req_code;
                    step_d   = 3'h0;
                    addr_d   = i_req_addr;
                    wdata_d  = i_req_wdata;
                    state_d  = NVSC_SETUP;
                end
            end
            NVSC_SETUP:
            begin
                if (is_cmd_q)
                begin
                    // bits 14..2 carry the command, the rest stay zero
                    addr_d = '0;
                    addr_d[`NVSC_CMD_MSB:`NVSC_CMD_LSB] =
                        step_addr[`NVSC_CMD_MSB:`NVSC_CMD_LSB];
                end
                cs_n_d  = 1'b0;
                oe_n_d  = is_wr_q;
                we_n_d  = !is_wr_q;
                dq_oe_d = is_wr_q;
                cnt_d   = CNT_W'(RD_CY);
                state_d = NVSC_STROBE;
            end
            NVSC_STROBE:
            begin
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                else
                begin
                    cs_n_d  = 1'b1;
                    oe_n_d  = 1'b1;
                    we_n_d  = 1'b1;
                    dq_oe_d = 1'b0;
                    // sixth read returns no data
                    if (!is_wr_q && !(is_cmd_q && step_q == `NVSC_LAST_STEP))
                        rdata_d = i_mem_dq;
                    cnt_d   = CNT_W'(GAP_CY);
                    state_d = NVSC_GAP;
                end
            end
            NVSC_GAP:
            begin
                if (cnt_q > CNT_W'(1))
                    cnt_d = cnt_q - CNT_W'(1);
                else if (is_cmd_q && step_q != `NVSC_LAST_STEP)
                begin
                    // next step follows directly so nothing else intervenes
                    step_d  = step_q + 3'h1;
                    state_d = NVSC_SETUP;
                end
                else if (is_cmd_q && code_q == `NVSC_CMD_RST_C)
                begin
                    cnt_d   = CNT_W'(RESTORE_CY);
                    state_d = NVSC_WAIT_NV;
                end
                else if (is_cmd_q)
                begin
                    // enable changes wait here too, then a save is chained
                    cnt_d   = CNT_W'(SAVE_CY);
                    state_d = NVSC_WAIT_NV;
                end
                else
                begin
                    rsp_d   = 1'b1;
                    state_d = NVSC_WAIT_BUSY;
                end
            end
            NVSC_WAIT_NV:
            begin
                // busy release may end the wait early for a save
                if (cnt_q > CNT_W'(1) && !(code_q != `NVSC_CMD_RST_C &&
                    code_q != `NVSC_CMD_ENA_OFF && code_q != `NVSC_CMD_ENA_ON &&
                    i_save_busy_handshake_n && cnt_q < CNT_W'(SAVE_CY - 1)))
                    cnt_d = cnt_q - CNT_W'(1);
                else if (code_q == `NVSC_CMD_ENA_OFF || code_q == `NVSC_CMD_ENA_ON)
                begin
                    // a new enable is lost at power-down unless a save follows
                    code_d  = `NVSC_CMD_SAVE_C;
                    step_d  = 3'h0;
                    state_d = NVSC_SETUP;
                end
                else
                begin
                    rsp_d   = 1'b1;
                    state_d = NVSC_WAIT_BUSY;
                end
            end
            NVSC_WAIT_BUSY:
            begin
                // busy release gates the next access, write strobe stays high
                if (i_save_busy_handshake_n)
                    state_d = NVSC_IDLE;
            end
            default:
                state_d = NVSC_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_resetn)
        begin
            state_q  <= NVSC_IDLE;
            cnt_q    <= '0;
            step_q   <= 3'h0;
            is_cmd_q <= 1'b0;
            is_wr_q  <= `NVSC_OP_READ;
            code_q   <= 3'h0;
            addr_q   <= '0;
            wdata_q  <= '0;
            ready_q  <= 1'b0;
            rsp_q    <= 1'b0;
            rdata_q  <= '0;
            cs_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            we_n_q   <= 1'b1;
            dq_oe_q  <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            step_q   <= step_d;
            is_cmd_q <= is_cmd_d;
            is_wr_q  <= is_wr_d;
            code_q   <= code_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            ready_q  <= ready_d;
            rsp_q    <= rsp_d;
            rdata_q  <= rdata_d;
            cs_n_q   <= cs_n_d;
            oe_n_q   <= oe_n_d;
            we_n_q   <= we_n_d;
            dq_oe_q  <= dq_oe_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_req_ready           = ready_q;
    assign o_rsp_valid           = rsp_q;
    assign o_rsp_rdata           = rdata_q;
    assign o_mem_addr            = addr_q;
    assign o_mem_chip_sel_n      = cs_n_q;
    assign o_mem_out_en_n        = oe_n_q;
    assign o_mem_write_n         = we_n_q;
    assign o_upper_byte_select_n = cs_n_q;
    assign o_lower_byte_select_n = cs_n_q;
    assign o_mem_dq              = wdata_q;
    assign o_mem_dq_oe           = dq_oe_q;
endmodule : nvsc_host
`default_nettype wire

// ===== nvsc_regs.svh
`ifndef NVSC_REGS_SVH
`define NVSC_REGS_SVH
`define NVSC_CMD_A1      16'h4E38
`define NVSC_CMD_A2      16'hB1C7
`define NVSC_CMD_A3      16'h83E0
`define NVSC_CMD_A4      16'h7C1F
`define NVSC_CMD_A5      16'h703F
`define NVSC_CMD_RESTORE 16'h4C63
`define NVSC_CMD_SAVE    16'h8FC0
`define NVSC_CMD_AS_OFF  16'h8B45
`define NVSC_CMD_AS_ON   16'h4B46
`define NVSC_CMD_MSB     14
`define NVSC_CMD_LSB     2
`define NVSC_LAST_STEP   3'h5
`define NVSC_CMD_ENA_OFF 3'h0
`define NVSC_CMD_ENA_ON  3'h1
`define NVSC_CMD_SAVE_C  3'h2
`define NVSC_CMD_RST_C   3'h3
`define NVSC_OP_READ     1'h0
`define NVSC_OP_WRITE    1'h1
`define NVSC_RD_PULSE_NS 30
`define NVSC_GAP_NS      20
`define NVSC_CLK_NS      10
`define NVSC_RESTORE_NS  200000
`define NVSC_SAVE_NS     8000000
`endif

// ===== nvsc_pkg.sv
`default_nettype none
package nvsc_pkg;
    typedef enum logic [2:0] {
        NVSC_IDLE,
        NVSC_SETUP,
        NVSC_STROBE,
        NVSC_GAP,
        NVSC_WAIT_NV,
        NVSC_WAIT_BUSY
    } nvsc_state_e;
endpackage : nvsc_pkg
`default_nettype wire

// ===== nvsc_host_asserts.sv
`default_nettype none
module nvsc_host_chk #(
    parameter int ADDR_W = 20
) (
    // clock, reset and enable
    input wire logic              i_core_clk,
    input wire logic              i_resetn,
    input wire logic              i_ce,
    // user side
    input wire logic              i_req_valid,
    input wire logic              i_req_write,
    input wire logic              i_req_cmd,
    input wire logic [2:0]        i_req_code,
    input wire logic              i_low_supply,
    input wire logic              o_req_ready,
    input wire logic              o_rsp_valid,
    // memory side
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic              o_mem_chip_sel_n,
    input wire logic              o_mem_out_en_n,
    input wire logic              o_mem_write_n,
    input wire logic              o_mem_dq_oe,
    input wire logic              o_upper_byte_select_n,
    input wire logic              o_lower_byte_select_n,
    input wire logic              i_save_busy_handshake_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    chk_read_no_write: assert property (!o_mem_out_en_n |-> o_mem_write_n)
        else $error("write strobe low during a read");
    chk_read_selected: assert property (!o_mem_out_en_n |-> !o_mem_chip_sel_n)
        else $error("output strobe without chip select");
    chk_lanes_follow: assert property (o_upper_byte_select_n == o_mem_chip_sel_n
        && o_lower_byte_select_n == o_mem_chip_sel_n) else $error("byte lanes differ from select");
    chk_strobe_len: assert property ($fell(o_mem_out_en_n) |-> !o_mem_out_en_n[*3]
        ##1 o_mem_out_en_n[*3]) else $error("read strobe or gap length wrong");
    chk_addr_held: assert property (!o_mem_chip_sel_n && !$past(o_mem_chip_sel_n)
        |-> $stable(o_mem_addr)) else $error("address moved inside a cycle");
    chk_busy_blocks: assert property (!i_save_busy_handshake_n && i_ce |=> !o_req_ready)
        else $error("ready while device busy");
    chk_low_refuse: assert property (i_low_supply && i_req_valid && o_req_ready
        && i_save_busy_handshake_n
        && (i_req_write && !i_req_cmd || i_req_cmd && i_req_code == 3'h2) |=> o_req_ready)
        else $error("write or save taken at low supply");
    chk_plain_answer: assert property (i_req_valid && o_req_ready && !i_req_cmd
        && !i_low_supply && i_ce && i_save_busy_handshake_n |-> ##[7:9] o_rsp_valid)
        else $error("plain access answer late");
    chk_drive_write: assert property (o_mem_dq_oe == !o_mem_write_n)
        else $error("data driven outside a write strobe");
endmodule : nvsc_host_chk
bind nvsc_host nvsc_host_chk #(.ADDR_W(ADDR_W)) i_chk (.i_core_clk, .i_resetn, .i_ce,
    .i_req_valid, .i_req_write, .i_req_cmd, .i_req_code, .i_low_supply, .o_req_ready,
    .o_rsp_valid, .o_mem_addr, .o_mem_chip_sel_n, .o_mem_out_en_n, .o_mem_write_n,
    .o_mem_dq_oe, .o_upper_byte_select_n, .o_lower_byte_select_n, .i_save_busy_handshake_n);
`default_nettype wire

// ===== nvsc_mem_model.sv
`default_nettype none
module nvsc_mem_model #(
    parameter int BUSY_CY = 40
) (
    input  wire logic        clk,
    input  wire logic [19:0] a,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [15:0] d,
    input  wire logic        low,
    output logic      [15:0] q,
    output logic             busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // only address bits 5..0 pick a word, enough for the bench
    logic [15:0] sram [64];
    logic [15:0] nv [64] = '{default: 16'h0000};
    logic [15:0] k [9] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F,
                           16'h4C63, 16'h8FC0, 16'h8B45, 16'h4B46};
    logic [19:0] al;
    logic        as_en = 1'b1;
    logic        as_nv = 1'b1;
    logic        wr = 1'b0, csq = 1'b1, hold = 1'b0, sv = 1'b0;
    int          step = 0, cnt = 0;
    initial q = 16'h5A5A;
    assign busy_n = !(cnt > 0 && sv);
    always @(posedge clk)
    begin
        // deselected bus toggles so a stale value never passes as read data
        q <= (!cs_n && !oe_n && we_n && cnt == 0) ? sram[a[5:0]] : ~q;
        if (!cs_n && !we_n && cnt == 0 && !low && !hold) sram[a[5:0]] <= d;
        hold <= (cnt == 1 || hold) && !cs_n && !we_n;
        if (!cs_n) al <= a;
        wr <= (cs_n && !csq) ? 1'b0 : wr || (!cs_n && !we_n);
        csq <= cs_n;
        if (cnt > 0) cnt <= cnt - 1;
        if (cs_n && !csq && cnt == 0)
        begin
            if (wr) step <= 0;
            else if (step < 5) step <= (al[14:2] == k[step][14:2]) ? step + 1 :
                int'(al[14:2] == k[0][14:2]);
            else
            begin
                step <= 0;
                if (al[14:2] == k[5][14:2])
                begin
                    // clear and copy land in one edge; reads are refused meanwhile
                    sram <= nv;
                    cnt <= BUSY_CY;
                    sv <= 1'b0;
                end
                if (al[14:2] == k[6][14:2] && !low)
                begin
                    nv <= sram;
                    as_nv <= as_en;
                    cnt <= BUSY_CY;
                    sv <= 1'b1;
                end
                if (al[14:2] == k[7][14:2]) as_en <= 1'b0;
                if (al[14:2] == k[8][14:2]) as_en <= 1'b1;
            end
        end
    end
endmodule : nvsc_mem_model
`default_nettype wire

// ===== tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rstn = 0, vld = 0, wr = 0, cmd = 0, low = 0, ce = 1;
    logic [2:0]  code = 0;
    logic [19:0] addr = 0, maddr;
    logic [15:0] wd = 0, mq, mdq, rdata;
    logic        rdy, rsp, cs_n, oe_n, we_n, dq_oe, busy_n;
    int          n_mismatch = 0, checks_done = 0, ncs = 0;
    always #5 clk = ~clk;
    always @(negedge cs_n) ncs++;
    nvsc_host #(.RESTORE_CY(50), .SAVE_CY(100)) i_nvsc_host (.i_core_clk(clk), .i_resetn(rstn),
        .i_ce(ce), .i_req_valid(vld), .i_req_write(wr), .i_req_cmd(cmd), .i_req_code(code),
        .i_req_addr(addr), .i_req_wdata(wd), .i_low_supply(low), .o_req_ready(rdy),
        .o_rsp_valid(rsp), .o_rsp_rdata(rdata), .o_mem_addr(maddr), .o_mem_chip_sel_n(cs_n),
        .o_mem_out_en_n(oe_n), .o_mem_write_n(we_n), .o_upper_byte_select_n(),
        .o_lower_byte_select_n(), .i_mem_dq(mq), .o_mem_dq(mdq), .o_mem_dq_oe(dq_oe),
        .i_save_busy_handshake_n(busy_n));
    nvsc_mem_model #(.BUSY_CY(40)) i_nvsc_mem_model (.clk, .a(maddr), .cs_n, .oe_n, .we_n,
        .d(mdq), .low, .q(mq), .busy_n);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one request, held until taken, then wait for its answer
    task automatic req(input logic w, input logic c, input logic [2:0] k,
                       input logic [19:0] a, input logic [15:0] dv);
        int n = 0;
        {wr, cmd, code, addr, wd, vld} = {w, c, k, a, dv, 1'b1};
        while (!rdy && n++ < 3000) @(posedge clk) #1;
        @(posedge clk) #1 vld = 1'b0;
        while (!rsp && n++ < 6000) @(posedge clk) #1;
        if (n >= 6000) n_mismatch++;
    endtask : req
    task automatic t_access;
        for (int i = 0; i < 4; i++) req(1'b1, 1'b0, 3'h0, 20'(i * 4), 16'(16'hA500 + i));
        for (int i = 0; i < 4; i++)
        begin
            req(1'b0, 1'b0, 3'h0, 20'(i * 4), 16'h0000);
            chk(rdata, 16'(16'hA500 + i));
        end
    endtask : t_access
    task automatic t_low;
        int n = 0;
        low = 1'b1;
        {wr, cmd, code, addr, wd, vld} = {1'b1, 1'b0, 3'h0, 20'h8, 16'hBEEF, 1'b1};
        repeat (20) @(posedge clk) #1 n += int'(rsp);
        chk(16'(n), 16'h0000);
        chk(i_nvsc_mem_model.sram[8], 16'hA502);
        low = 1'b0;
        req(1'b1, 1'b0, 3'h0, 20'h8, 16'hBEEF);
        req(1'b0, 1'b0, 3'h0, 20'h8, 16'h0000);
        chk(rdata, 16'hBEEF);
    endtask : t_low
    // clock enable low: a standing request must not start a cycle
    task automatic t_freeze;
        int c0;
        int n = 0;
        repeat (3) @(posedge clk) #1;
        c0 = ncs;
        ce = 1'b0;
        {wr, cmd, code, addr, wd, vld} = {1'b0, 1'b0, 3'h0, 20'h4, 16'h0000, 1'b1};
        repeat (12) @(posedge clk) #1 n += int'(rsp);
        chk(16'(ncs - c0 + n), 16'h0000);
        ce = 1'b1;
        req(1'b0, 1'b0, 3'h0, 20'h4, 16'h0000);
        chk(rdata, 16'hA501);
    endtask : t_freeze
    task automatic t_nv;
        int c0 = ncs;
        req(1'b0, 1'b1, 3'h2, 20'h0, 16'h0);
        chk(16'(ncs - c0), 16'h0006);
        chk(i_nvsc_mem_model.nv[8], 16'hBEEF);
        req(1'b1, 1'b0, 3'h0, 20'h8, 16'h5678);
        req(1'b0, 1'b1, 3'h3, 20'h0, 16'h0);
        chk(i_nvsc_mem_model.nv[8], 16'hBEEF);
        req(1'b0, 1'b0, 3'h0, 20'h8, 16'h0000);
        chk(rdata, 16'hBEEF);
    endtask : t_nv
    task automatic t_autosave;
        chk(16'(i_nvsc_mem_model.as_en), 16'h0001);
        req(1'b0, 1'b1, 3'h0, 20'h0, 16'h0);
        chk(16'(i_nvsc_mem_model.as_en), 16'h0000);
        chk(16'(i_nvsc_mem_model.as_nv), 16'h0000);
        req(1'b0, 1'b1, 3'h2, 20'h0, 16'h0);
        chk(16'(i_nvsc_mem_model.as_nv), 16'h0000);
        req(1'b0, 1'b1, 3'h1, 20'h0, 16'h0);
        chk(16'(i_nvsc_mem_model.as_en), 16'h0001);
        chk(16'(i_nvsc_mem_model.as_nv), 16'h0001);
    endtask : t_autosave
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        @(posedge clk) #1;
        chk(i_nvsc_mem_model.nv[40], 16'h0000);
        t_access();
        t_low();
        t_freeze();
        t_nv();
        t_autosave();
        tally_and_finish();
    end
    // whole run needs about 900 cycles; allow over thirty times that
    initial
    begin
        #300us;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
